/* logic/fdsr_core.sv */
// Result status bytes, reset sources, host modes and DMA start.
// Assumes AHB-Lite single word transfers, sector events on ref_clk,
// and asynchronous pins that are synchronised here.
//
// Summary of operation
// - Status two bits 7,3,2 read zero
// - Mark type mismatch sets control-mark flag
// - Data field CRC failure sets bit 5
// - ID track mismatch sets wrong-track flag
// - Mismatch with track FF sets bad-track
// - No data mark found sets bit 0
// - Status three shows live drive lines
// - Status three bits 5,3 one, 7 zero
// - Three reset sources; any leaves power-down
// - Any reset aborts operation, goes idle
// - Reset clears configuration; polling starts
// - Pin reset spares specify parameters
// - Pin reset sets output-register reset bit
// - Both software resets reset the core
// - Rate reset self-clears; output reset wins
// - Mode from config three bits 6,5
// - Identity high: DMA gates, active-high levels
// - Encoding only: always driven, active low
// - Both low: gated, TC high, density low
// - Specify DMA raises request; acknowledge selects FIFO
// - Verify pseudo read on acknowledge, byte mode
// - Command, execution, result phases in turn
// - Density high after pin reset only
//
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module fdsr_core (
	// Clock and power-on reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Asynchronous pins
	input wire logic hw_reset_pin,
	input wire fdsr_pkg::fdsr_drive_pins_t drive_pins,
	input wire logic dma_acknowledge_n,
	input wire logic terminal_count_pin,
	// Datapath events on ref_clk
	input wire fdsr_pkg::fdsr_sector_ev_t sector_ev,
	input wire logic [7:0] current_track,
	// Host side outputs
	output logic controller_interrupt_out,
	output logic controller_interrupt_oe,
	output logic transfer_request_out,
	output logic transfer_request_oe,
	output logic fifo_select,
	output logic pseudo_read_strobe,
	// Drive side outputs
	output logic density_select_output,
	output logic head_select_output,
	output logic [1:0] drive_select_lines,
	// Core control outputs
	output logic core_reset,
	output logic polling_enable,
	output logic power_down
);

	////////////////////////////////////////////////////////////////
	// Functions

	// Word address match; low two bits are byte lanes
	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] r);
		reg_hit = (a[7:2] == r[7:2]);
	endfunction : reg_hit

	// Density level for a rate code and identity select
	function automatic logic dens_for(input logic [1:0] rate, input logic ident);
		dens_for = (rate <= fdsr_pkg::RATE_FAST_MAX) ? ident : ~ident;
	endfunction : dens_for

	////////////////////////////////////////////////////////////////
	// Pin synchronisers

	// Collected pin levels
	logic [fdsr_pkg::SY_W-1:0] pin_raw;
	// First and second stage
	logic [fdsr_pkg::SY_W-1:0] sy1_reg;
	logic [fdsr_pkg::SY_W-1:0] sy2_reg;
	// Delayed acknowledge for edge detect
	logic ack_d_reg;

	assign pin_raw[fdsr_pkg::SY_PRST] = hw_reset_pin;
	assign pin_raw[fdsr_pkg::SY_WP] = drive_pins.write_protect;
	assign pin_raw[fdsr_pkg::SY_T0] = drive_pins.track_zero_input;
	assign pin_raw[fdsr_pkg::SY_ACKN] = dma_acknowledge_n;
	assign pin_raw[fdsr_pkg::SY_TC] = terminal_count_pin;

	// One two-stage chain per pin; only stage two is read
	genvar gi;
	generate
		for (gi = 0; gi < fdsr_pkg::SY_W; gi++) begin : g_sync
			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					sy1_reg[gi] <= fdsr_pkg::SY_IDLE[gi];
					sy2_reg[gi] <= fdsr_pkg::SY_IDLE[gi];
				end else begin
					sy1_reg[gi] <= pin_raw[gi];
					sy2_reg[gi] <= sy1_reg[gi];
				end
			end
		end
	endgenerate

	// Edge detector works off stage two only
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_d_reg <= 1'b0;
		end else begin
			ack_d_reg <= ~sy2_reg[fdsr_pkg::SY_ACKN];
		end
	end

	// Clean pin levels
	wire pin_rst = sy2_reg[fdsr_pkg::SY_PRST];
	wire ack_act = ~sy2_reg[fdsr_pkg::SY_ACKN];
	wire ack_rise = ack_act & ~ack_d_reg;

	////////////////////////////////////////////////////////////////
	// AHB-Lite slave

	// Data phase address and direction
	logic [7:0] addr_reg;
	logic wr_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	// Valid transfer in address phase; hsize always a word
	wire ahb_go = hsel & htrans[1] & hready;
	wire rd_go = ahb_go & ~hwrite;

	// Address phase capture
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			addr_reg <= 8'h00;
			wr_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			addr_reg <= haddr[7:0];
			wr_reg <= ahb_go & hwrite;
			rdata_reg <= rd_go ? rdata_next : 32'h0000_0000;
		end
	end

	// Data phase write strobes
	wire wr_dor = wr_reg & reg_hit(addr_reg, fdsr_pkg::ADDR_DOR);
	wire wr_dsr = wr_reg & reg_hit(addr_reg, fdsr_pkg::ADDR_DSR);
	wire wr_cfg = wr_reg & reg_hit(addr_reg, fdsr_pkg::ADDR_CFG3);
	wire wr_spec = wr_reg & reg_hit(addr_reg, fdsr_pkg::ADDR_SPEC);
	wire wr_cmd = wr_reg & reg_hit(addr_reg, fdsr_pkg::ADDR_CMD);
	// Reading status two closes the result phase
	wire rd_st2 = rd_go & reg_hit(haddr[7:0], fdsr_pkg::ADDR_ST2);

	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_reg;

	////////////////////////////////////////////////////////////////
	// Control registers and resets

	logic [7:0] dor_reg;
	logic [7:0] dsr_reg;
	logic [7:0] cfg_reg;
	logic [7:0] spec_reg;
	logic dens_reg;

	// Software resets; the output bit holds, the rate bit pulses
	wire dor_rst = dor_reg[fdsr_pkg::DOR_RST];
	wire dsr_rst = dsr_reg[fdsr_pkg::DSR_RST];
	// Every source resets the core alike
	assign core_reset = pin_rst | dor_rst | dsr_rst;

	// Output register; pin reset forces its reset bit set
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			dor_reg <= fdsr_pkg::DOR_PIN_RST_VAL;
		end else if (pin_rst) begin
			dor_reg <= fdsr_pkg::DOR_PIN_RST_VAL;
		end else if (wr_dor) begin
			dor_reg <= hwdata[7:0];
		end
	end

	// Rate register; reset bit clears itself next cycle
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			dsr_reg <= fdsr_pkg::DSR_RST_VAL;
		end else if (pin_rst) begin
			dsr_reg <= fdsr_pkg::DSR_RST_VAL;
		end else if (wr_dsr) begin
			dsr_reg <= hwdata[7:0];
			// Output reset wins; no second pulse under it
			dsr_reg[fdsr_pkg::DSR_RST] <= hwdata[fdsr_pkg::DSR_RST] & ~dor_rst;
			dsr_reg[fdsr_pkg::DSR_PD] <= hwdata[fdsr_pkg::DSR_PD] & ~core_reset;
		end else begin
			dsr_reg[fdsr_pkg::DSR_RST] <= 1'b0;
			// Any reset drops power-down
			if (core_reset) begin
				dsr_reg[fdsr_pkg::DSR_PD] <= 1'b0;
			end
		end
	end

	// Configuration cleared by every reset
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_reg <= 8'h00;
		end else if (core_reset) begin
			cfg_reg <= 8'h00;
		end else if (wr_cfg) begin
			cfg_reg <= hwdata[7:0];
		end
	end

	// Specify parameters survive pin and software resets
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			spec_reg <= 8'h00;
		end else if (wr_spec) begin
			spec_reg <= hwdata[7:0];
		end
	end

	// Density level; pin reset sets it, soft resets leave it
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			dens_reg <= 1'b1;
		end else if (pin_rst) begin
			dens_reg <= 1'b1;
		end else if (wr_dsr) begin
			dens_reg <= dens_for(hwdata[1:0], cfg_reg[fdsr_pkg::CFG_IDENT]);
		end
	end

	assign power_down = dsr_reg[fdsr_pkg::DSR_PD];
	// Polling runs until configuration turns it off
	assign polling_enable = ~cfg_reg[fdsr_pkg::CFG_POLL_OFF];
	assign density_select_output = dens_reg;
	assign drive_select_lines = dor_reg[fdsr_pkg::DOR_DS +: 2];

	////////////////////////////////////////////////////////////////
	// Host mode decode

	// Identity select wins over encoding select
	wire ident = cfg_reg[fdsr_pkg::CFG_IDENT];
	wire enc = cfg_reg[fdsr_pkg::CFG_ENC];
	// Only encoding-only mode drives the outputs always
	wire always_drive = ~ident & enc;
	// Terminal count active low only in encoding-only mode
	wire tc_act = sy2_reg[fdsr_pkg::SY_TC] ^ always_drive;
	// Output enables follow the DMA gate unless always driven
	wire gate_on = always_drive | dor_reg[fdsr_pkg::DOR_DMA];

	////////////////////////////////////////////////////////////////
	// Phase machine

	fdsr_pkg::fdsr_phase_t phase_reg;
	fdsr_pkg::fdsr_phase_t phase_next;
	fdsr_pkg::fdsr_op_t op_reg;
	logic head_reg;
	logic tc_seen_reg;

	// Next phase; reset takes priority
	always_comb begin
		phase_next = phase_reg;
		unique case (phase_reg)
			fdsr_pkg::PH_CMD: begin
				if (wr_cmd) begin
					phase_next = fdsr_pkg::PH_EXEC;
				end
			end
			fdsr_pkg::PH_EXEC: begin
				if (sector_ev.exec_done) begin
					phase_next = fdsr_pkg::PH_RES;
				end
			end
			fdsr_pkg::PH_RES: begin
				if (rd_st2) begin
					phase_next = fdsr_pkg::PH_CMD;
				end
			end
			default: begin
				phase_next = fdsr_pkg::PH_CMD;
			end
		endcase
		if (core_reset) begin
			phase_next = fdsr_pkg::PH_CMD;
		end
	end

	wire in_exec = (phase_reg == fdsr_pkg::PH_EXEC);
	wire in_res = (phase_reg == fdsr_pkg::PH_RES);
	wire start = wr_cmd & (phase_reg == fdsr_pkg::PH_CMD) & ~core_reset;

	// Phase and command registers
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_reg <= fdsr_pkg::PH_CMD;
			op_reg <= fdsr_pkg::OP_NONE;
			head_reg <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			if (core_reset) begin
				op_reg <= fdsr_pkg::OP_NONE;
				head_reg <= 1'b0;
			end else if (start) begin
				op_reg <= fdsr_fdsr_op(hwdata[fdsr_pkg::CMD_OP +: 2]);
				head_reg <= hwdata[fdsr_pkg::CMD_HEAD];
			end
		end
	end

	// Command code cast into the enum
	function automatic fdsr_pkg::fdsr_op_t fdsr_fdsr_op(input logic [1:0] c);
		fdsr_fdsr_op = fdsr_pkg::fdsr_op_t'(c);
	endfunction : fdsr_fdsr_op

	assign head_select_output = head_reg;

	////////////////////////////////////////////////////////////////
	// Status byte two

	logic [7:0] work_reg;
	logic [7:0] st2_reg;
	logic [7:0] ev_bits;

	wire rd_del = (op_reg == fdsr_pkg::OP_READ_DEL);
	wire is_read = (op_reg == fdsr_pkg::OP_READ) | rd_del;
	wire trk_miss = sector_ev.id_valid & (sector_ev.id_track != current_track);

	// Error events seen this cycle; unused bits stay zero
	always_comb begin
		ev_bits = 8'h00;
		ev_bits[fdsr_pkg::ST2_CM] = sector_ev.mark_valid & is_read
			& (sector_ev.mark_deleted ^ rd_del);
		ev_bits[fdsr_pkg::ST2_DD] = sector_ev.crc_bad;
		ev_bits[fdsr_pkg::ST2_WC] = trk_miss;
		ev_bits[fdsr_pkg::ST2_BC] = trk_miss
			& (sector_ev.id_track == fdsr_pkg::BAD_TRACK);
		ev_bits[fdsr_pkg::ST2_MD] = sector_ev.mark_missing;
	end

	// Accumulate during execution, latch at its end
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			work_reg <= 8'h00;
			st2_reg <= 8'h00;
		end else if (core_reset) begin
			work_reg <= 8'h00;
			st2_reg <= 8'h00;
		end else if (start) begin
			work_reg <= 8'h00;
		end else if (in_exec) begin
			work_reg <= work_reg | ev_bits;
			// Last cycle's events are folded in too
			if (sector_ev.exec_done) begin
				st2_reg <= work_reg | ev_bits;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Status byte three

	// Live pin and output levels with fixed bits
	logic [7:0] st3;
	always_comb begin
		st3 = fdsr_pkg::ST3_ONES;
		st3[fdsr_pkg::ST3_WP] = sy2_reg[fdsr_pkg::SY_WP];
		st3[fdsr_pkg::ST3_T0] = sy2_reg[fdsr_pkg::SY_T0];
		st3[fdsr_pkg::ST3_HD] = head_reg;
		st3[fdsr_pkg::ST3_DS +: 2] = drive_select_lines;
	end

	////////////////////////////////////////////////////////////////
	// DMA and interrupt

	wire dma_on = spec_reg[fdsr_pkg::SPEC_DMA];

	// Terminal count counts only with acknowledge
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			tc_seen_reg <= 1'b0;
		end else if (core_reset | start) begin
			tc_seen_reg <= 1'b0;
		end else if (in_exec & tc_act & ack_act) begin
			tc_seen_reg <= 1'b1;
		end
	end

	// Request held through execution until terminal count
	assign transfer_request_out = in_exec & dma_on & ~tc_seen_reg;
	assign transfer_request_oe = gate_on;
	// Result phase raises the interrupt
	assign controller_interrupt_out = in_res;
	assign controller_interrupt_oe = gate_on;
	// Acknowledge in DMA mode picks the FIFO, address ignored
	assign fifo_select = dma_on & ack_act;

	// Pseudo read for verify cycles in byte mode reads
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pseudo_read_strobe <= 1'b0;
		end else begin
			pseudo_read_strobe <= in_exec & is_read & dma_on & ack_rise
				& cfg_reg[fdsr_pkg::CFG_FIFO_OFF] & ~core_reset;
		end
	end

	////////////////////////////////////////////////////////////////
	// Read mux

	// Unmapped offsets read zero
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (reg_hit(haddr[7:0], fdsr_pkg::ADDR_DOR)) begin
			rdata_next[7:0] = dor_reg;
		end else if (reg_hit(haddr[7:0], fdsr_pkg::ADDR_DSR)) begin
			rdata_next[7:0] = dsr_reg;
		end else if (reg_hit(haddr[7:0], fdsr_pkg::ADDR_CFG3)) begin
			rdata_next[7:0] = cfg_reg;
		end else if (reg_hit(haddr[7:0], fdsr_pkg::ADDR_SPEC)) begin
			rdata_next[7:0] = spec_reg;
		end else if (reg_hit(haddr[7:0], fdsr_pkg::ADDR_ST2)) begin
			rdata_next[7:0] = st2_reg;
		end else if (reg_hit(haddr[7:0], fdsr_pkg::ADDR_ST3)) begin
			rdata_next[7:0] = st3;
		end else if (reg_hit(haddr[7:0], fdsr_pkg::ADDR_PHASE)) begin
			rdata_next[2:0] = phase_reg;
		end
	end

endmodule : fdsr_core

/* logic/fdsr_pkg.sv */
// Package for the floppy status, reset and mode block.
// Assumes one 200 MHz core clock and an AHB-Lite register bus.
package fdsr_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_DOR = 8'h00;
	localparam logic [7:0] ADDR_DSR = 8'h04;
	localparam logic [7:0] ADDR_CFG3 = 8'h08;
	localparam logic [7:0] ADDR_SPEC = 8'h0C;
	localparam logic [7:0] ADDR_CMD = 8'h10;
	localparam logic [7:0] ADDR_ST2 = 8'h14;
	localparam logic [7:0] ADDR_ST3 = 8'h18;
	localparam logic [7:0] ADDR_PHASE = 8'h1C;
	// Output register fields
	localparam int DOR_DS = 0;
	localparam int DOR_RST = 2;
	localparam int DOR_DMA = 3;
	localparam logic [7:0] DOR_PIN_RST_VAL = 8'h04;
	// Rate register fields
	localparam int DSR_RATE = 0;
	localparam int DSR_NOPREC = 2;
	localparam int DSR_PD = 6;
	localparam int DSR_RST = 7;
	localparam logic [7:0] DSR_RST_VAL = 8'h02;
	// Configuration register 3 fields
	localparam int CFG_IDENT = 6;
	localparam int CFG_ENC = 5;
	localparam int CFG_POLL_OFF = 4;
	localparam int CFG_FIFO_OFF = 3;
	// Specify and command fields
	localparam int SPEC_DMA = 0;
	localparam int CMD_OP = 0;
	localparam int CMD_HEAD = 2;
	// Second status byte fields
	localparam int ST2_CM = 6;
	localparam int ST2_DD = 5;
	localparam int ST2_WC = 4;
	localparam int ST2_BC = 1;
	localparam int ST2_MD = 0;
	// Third status byte fields
	localparam int ST3_WP = 6;
	localparam int ST3_T0 = 4;
	localparam int ST3_HD = 2;
	localparam int ST3_DS = 0;
	localparam logic [7:0] ST3_ONES = 8'h28;
	localparam logic [7:0] BAD_TRACK = 8'hFF;
	// Synchroniser bit positions and idle levels
	localparam int SY_PRST = 0;
	localparam int SY_WP = 1;
	localparam int SY_T0 = 2;
	localparam int SY_ACKN = 3;
	localparam int SY_TC = 4;
	localparam int SY_W = 5;
	localparam logic [4:0] SY_IDLE = 5'h08;
	// Rates at or below this code drive density equal to the identity select
	localparam logic [1:0] RATE_FAST_MAX = 2'h1;
	// Command phases, one-hot
	typedef enum logic [2:0] {
		PH_CMD = 3'b001,
		PH_EXEC = 3'b010,
		PH_RES = 3'b100
	} fdsr_phase_t;
	// Data transfer command codes
	typedef enum logic [1:0] {
		OP_READ = 2'h0,
		OP_READ_DEL = 2'h1,
		OP_WRITE = 2'h2,
		OP_NONE = 2'h3
	} fdsr_op_t;
	// Events from the read/write datapath, one cycle each
	typedef struct packed {
		logic id_valid;
		logic [7:0] id_track;
		logic mark_valid;
		logic mark_deleted;
		logic crc_bad;
		logic mark_missing;
		logic exec_done;
	} fdsr_sector_ev_t;
	// Drive sense pins, asynchronous
	typedef struct packed {
		logic write_protect;
		logic track_zero_input;
	} fdsr_drive_pins_t;
endpackage : fdsr_pkg

/* sim/fdsr_core_properties.sv */
// Checker for the status, reset and mode block.
// Assumes it sees only the core's ports; bound at the foot of this file.
`timescale 1ns/1ps
module fdsr_core_checker (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// Pins and core state
	input wire logic hw_reset_pin,
	input wire logic density_select_output,
	input wire logic head_select_output,
	input wire logic [1:0] drive_select_lines,
	input wire logic core_reset,
	input wire logic polling_enable,
	input wire logic power_down,
	input wire logic pseudo_read_strobe
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////
	// Data phase tracking
	logic rd_pend;
	logic wr_pend;
	logic [7:0] ph_addr;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_pend <= 1'b0;
			wr_pend <= 1'b0;
			ph_addr <= 8'h00;
		end else if (hready) begin
			rd_pend <= hsel && htrans[1] && !hwrite;
			wr_pend <= hsel && htrans[1] && hwrite;
			ph_addr <= haddr[7:0];
		end
	end
	// Decoded data phases
	wire rd_st2 = rd_pend && (ph_addr == fdsr_pkg::ADDR_ST2);
	wire rd_st3 = rd_pend && (ph_addr == fdsr_pkg::ADDR_ST3);
	wire wr_dsr = wr_pend && (ph_addr == fdsr_pkg::ADDR_DSR);
	wire wr_dor = wr_pend && (ph_addr == fdsr_pkg::ADDR_DOR);
	////////////////////////////////////////////////////////////
	chk_st2_zero: assert property (rd_st2 |-> hrdata[7] == 1'b0 && hrdata[3:2] == 2'h0)
		else $error("st2 zero bits set");
	chk_st3_const: assert property (rd_st3 |-> (hrdata[7:0] & 8'hA8) == 8'h28)
		else $error("st3 fixed bits");
	chk_st3_lines: assert property (rd_st3 |-> hrdata[2] == $past(head_select_output)
		&& hrdata[1:0] == $past(drive_select_lines))
		else $error("st3 drive lines");
	chk_pin_rst: assert property (hw_reset_pin [*5] |-> core_reset && density_select_output)
		else $error("pin reset effect");
	chk_pin_poll: assert property (hw_reset_pin [*5] |-> polling_enable)
		else $error("pin reset polling");
	chk_pd_exit: assert property ($fell(core_reset) |-> !power_down)
		else $error("power down kept");
	chk_dsr_selfclr: assert property (wr_dsr && hwdata[7] && !core_reset
		|=> core_reset ##[1:2] !core_reset)
		else $error("rate reset pulse");
	chk_dens_hold: assert property (wr_dor && !hw_reset_pin |=> $stable(density_select_output))
		else $error("density moved");
	chk_strobe_pulse: assert property (pseudo_read_strobe |=> !pseudo_read_strobe)
		else $error("pseudo read too long");
	// Main scenarios reached
	cov_cm_read: cover property (rd_st2 && hrdata[6]);
	cov_rst_exit: cover property ($fell(core_reset));
	cov_pseudo: cover property (pseudo_read_strobe);
endmodule : fdsr_core_checker

bind fdsr_core fdsr_core_checker i_fdsr_core_checker (.ref_clk, .rst_b, .hsel, .haddr, .htrans,
	.hwrite, .hwdata, .hready, .hrdata, .hw_reset_pin, .density_select_output,
	.head_select_output, .drive_select_lines, .core_reset, .polling_enable, .power_down,
	.pseudo_read_strobe);

/* sim/fdsr_core_tb.sv */
// Testbench for the status, reset and mode block.
// Assumes a lone AHB-Lite slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
module fdsr_core_tb;
	////////////////////////////////////////////////////////////
	logic ref_clk, rst_b, hsel, hwrite, hready, hreadyout, hresp, hw_reset_pin;
	logic [31:0] haddr, hwdata, hrdata, rd_cap, pr_cnt, base;
	logic [1:0] htrans, drive_select_lines;
	logic [2:0] hsize;
	logic [7:0] current_track;
	logic [3:0] ack_delay;
	logic tc_high, dma_acknowledge_n, terminal_count_pin, core_reset, power_down;
	logic controller_interrupt_out, controller_interrupt_oe, transfer_request_out;
	logic transfer_request_oe, pseudo_read_strobe, density_select_output;
	logic head_select_output, polling_enable, fifo_select;
	fdsr_pkg::fdsr_drive_pins_t drive_pins;
	fdsr_pkg::fdsr_sector_ev_t sector_ev;
	int errors, n_checks, n;
	assign hready = hreadyout;
	// Clock at 200 MHz
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// Read data and pseudo reads as seen at each edge
	always @(posedge ref_clk) begin
		rd_cap <= hrdata;
		pr_cnt <= pr_cnt + 32'(pseudo_read_strobe);
	end
	fdsr_core i_fdsr_core (.ref_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hrdata, .hreadyout, .hresp, .hw_reset_pin, .drive_pins, .dma_acknowledge_n,
		.terminal_count_pin, .sector_ev, .current_track, .controller_interrupt_out,
		.controller_interrupt_oe, .transfer_request_out, .transfer_request_oe, .fifo_select,
		.pseudo_read_strobe, .density_select_output, .head_select_output, .drive_select_lines,
		.core_reset, .polling_enable, .power_down);
	fdsr_dma_model i_fdsr_dma_model (.ref_clk, .tc_high, .ack_delay, .transfer_request_out,
		.transfer_request_oe, .dma_acknowledge_n, .terminal_count_pin);
	////////////////////////////////////////////////////////////
	// Comparisons
	task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_word
	task automatic chk_bit(input string nm, input logic e, input logic g);
		chk_word(nm, {31'h0, e}, {31'h0, g});
	endtask : chk_bit
	// One single transfer; a hang counts as a mismatch
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		n = 0;
		@(posedge ref_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hready !== 1'b1 && n < 64);
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hready !== 1'b1 && n < 64);
		@(negedge ref_clk);
		rd = rd_cap;
		if (n >= 64) errors++;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		bus(1'b1, a, {24'h0, d}, r);
	endtask : wr
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk_word(nm, e, r);
	endtask : rc
	// One cycle of datapath events
	task automatic ev(input fdsr_pkg::fdsr_sector_ev_t e);
		@(posedge ref_clk);
		sector_ev <= e;
		@(posedge ref_clk);
		sector_ev <= '0;
	endtask : ev
	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : complete_run
	// Watchdog well past the test length
	initial begin
		#100000;
		errors++;
		complete_run;
	end
	////////////////////////////////////////////////////////////
	// Tables: status rows, mode rows
	logic [7:0] cmd_t [3] = '{8'h04, 8'h01, 8'h00};
	logic [7:0] trk_t [3] = '{8'hFF, 8'h05, 8'h07};
	logic [3:0] flg_t [3] = '{4'b1110, 4'b0101, 4'b0000};
	logic [7:0] st2_t [3] = '{8'h73, 8'h60, 8'h10};
	logic [7:0] cfg_t [3] = '{8'h40, 8'h20, 8'h08};
	localparam logic [7:0] A_OUT = fdsr_pkg::ADDR_DOR, A_RATE = fdsr_pkg::ADDR_DSR,
		A_CFG = fdsr_pkg::ADDR_CFG3, A_SPEC = fdsr_pkg::ADDR_SPEC, A_CMD = fdsr_pkg::ADDR_CMD,
		A_ST2 = fdsr_pkg::ADDR_ST2, A_ST3 = fdsr_pkg::ADDR_ST3, A_PH = fdsr_pkg::ADDR_PHASE;
	initial begin
		{rst_b, hsel, hwrite, hw_reset_pin, tc_high} = 5'h00;
		{haddr, hwdata, pr_cnt} = 96'h0;
		{htrans, hsize, ack_delay} = 9'h020;
		current_track = 8'h05;
		drive_pins = 2'b10;
		sector_ev = '0;
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		rc("out_reg", A_OUT, 32'h4);
		chk_bit("hresp", 1'b0, hresp);
		chk_bit("core_reset", 1'b1, core_reset);
		chk_bit("density", 1'b1, density_select_output);
		chk_bit("polling", 1'b1, polling_enable);
		rc("rate_reg", A_RATE, 32'h2);
		rc("phase", A_PH, 32'h1);
		wr(8'h20, 8'hFF);
		rc("unmapped", 8'h20, 32'h0);
		wr(A_OUT, 8'h01);
		chk_bit("core_reset", 1'b0, core_reset);
		// Status two rows, status three live lines in the first
		for (int i = 0; i < 3; i++) begin
			wr(A_CMD, cmd_t[i]);
			rc("phase", A_PH, 32'h2);
			if (i == 0) begin
				rc("st3", A_ST3, 32'h6D);
				drive_pins <= 2'b01;
				repeat (3) @(posedge ref_clk);
				rc("st3", A_ST3, 32'h3D);
			end
			// Struct order: ID valid, ID track, mark valid, four flags
			ev({1'b1, trk_t[i], 1'b1, flg_t[i]});
			if (!flg_t[i][0]) ev(14'h0001);
			rc("phase", A_PH, 32'h4);
			chk_bit("irq", 1'b1, controller_interrupt_out);
			rc("st2", A_ST2, {24'h0, st2_t[i]});
			rc("phase", A_PH, 32'h1);
		end
		// Software reset in mid-execution aborts
		wr(A_CMD, 8'h00);
		wr(A_OUT, 8'h05);
		rc("phase", A_PH, 32'h1);
		// Output enables per mode and gate; output write first ends the reset
		for (int m = 0; m < 6; m++) begin
			wr(A_OUT, {4'h0, m[0], 3'h1});
			wr(A_CFG, cfg_t[m / 2] & 8'h60);
			chk_bit("irq_oe", (m / 2 == 1) | m[0], controller_interrupt_oe);
			chk_bit("req_oe", (m / 2 == 1) | m[0], transfer_request_oe);
		end
		// DMA request ended by qualified count, per mode polarity
		for (int m = 0; m < 3; m++) begin
			tc_high <= (m != 1);
			ack_delay <= 4'(m * 3);
			wr(A_CFG, cfg_t[m]);
			wr(A_OUT, 8'h09);
			wr(A_SPEC, 8'h01);
			base = pr_cnt;
			wr(A_CMD, 8'h00);
			for (n = 0; n < 40 && transfer_request_out !== 1'b1; n++) @(negedge ref_clk);
			chk_bit("request", 1'b1, transfer_request_out);
			for (n = 0; n < 40 && transfer_request_out !== 1'b0; n++) @(negedge ref_clk);
			chk_bit("request", 1'b0, transfer_request_out);
			chk_bit("fifo_select", 1'b1, fifo_select);
			ev(14'h0001);
			rc("st2", A_ST2, 32'h0);
			chk_word("pseudo", base + 32'(m == 2), pr_cnt);
		end
		// Power-down left by reset; rate reset self-clears, output reset wins
		wr(A_RATE, 8'h40);
		chk_bit("power_down", 1'b1, power_down);
		wr(A_RATE, 8'hC0);
		@(negedge ref_clk);
		chk_bit("power_down", 1'b0, power_down);
		rc("rate_reg", A_RATE, 32'h0);
		wr(A_OUT, 8'h05);
		wr(A_RATE, 8'hC0);
		wr(A_OUT, 8'h01);
		chk_bit("core_reset", 1'b0, core_reset);
		chk_bit("power_down", 1'b0, power_down);
		// Density from rate and identity; software resets leave it
		wr(A_CFG, 8'h00);
		wr(A_RATE, 8'h00);
		chk_bit("density", 1'b0, density_select_output);
		wr(A_OUT, 8'h05);
		chk_bit("density", 1'b0, density_select_output);
		wr(A_OUT, 8'h01);
		wr(A_RATE, 8'h80);
		chk_bit("density", 1'b0, density_select_output);
		wr(A_CFG, 8'h40);
		wr(A_RATE, 8'h00);
		chk_bit("density", 1'b1, density_select_output);
		wr(A_RATE, 8'h03);
		chk_bit("density", 1'b0, density_select_output);
		// Pin reset keeps specify only
		wr(A_CFG, 8'h10);
		chk_bit("polling", 1'b0, polling_enable);
		hw_reset_pin <= 1'b1;
		repeat (6) @(posedge ref_clk);
		hw_reset_pin <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rc("out_reg", A_OUT, 32'h4);
		rc("specify", A_SPEC, 32'h1);
		rc("cfg3", A_CFG, 32'h0);
		chk_bit("density", 1'b1, density_select_output);
		chk_bit("polling", 1'b1, polling_enable);
		chk_bit("core_reset", 1'b1, core_reset);
		complete_run;
	end
endmodule : fdsr_core_tb

/* sim/fdsr_dma_model.sv */
// DMA controller model on the far side of the request line.
// Assumes acknowledge is active low and idles high when released.
`timescale 1ns/1ps
module fdsr_dma_model (
	// Clock
	input wire logic ref_clk,
	// Bench controls
	input wire logic tc_high,
	input wire logic [3:0] ack_delay,
	// Device side
	input wire logic transfer_request_out,
	input wire logic transfer_request_oe,
	output logic dma_acknowledge_n,
	output logic terminal_count_pin
);
	logic [3:0] wait_cnt; // Cycles the request has waited
	initial begin
		dma_acknowledge_n = 1'b1;
		terminal_count_pin = 1'b0;
		wait_cnt = 4'h0;
	end
	// Acknowledge a driven request after ack_delay cycles
	always @(posedge ref_clk) begin
		if (transfer_request_oe && transfer_request_out) begin
			wait_cnt <= wait_cnt + 4'h1;
			if (wait_cnt >= ack_delay) begin
				dma_acknowledge_n <= 1'b0;
				terminal_count_pin <= tc_high;
			end
		end else begin
			// Released: idle levels, so a stale count is never seen
			wait_cnt <= 4'h0;
			dma_acknowledge_n <= 1'b1;
			terminal_count_pin <= ~tc_high;
		end
	end
endmodule : fdsr_dma_model
